// file: pkg/pwmfbc_pkg.sv
package pwmfbc_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [3:0] ADDR_FLT_CTL = 4'h0;
	localparam logic [3:0] ADDR_LEB_CTL = 4'h4;
	localparam logic [3:0] ADDR_LEB_DLY = 4'h8;
	localparam logic [3:0] ADDR_AUX_CTL = 4'hC;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_UNLOCK = 8'h18;
	localparam logic [7:0] ADDR_FLT_CLR = 8'h1C;
	// ==========================================
	// field positions and reset values
	localparam int FLT_MODE_LSB = 0;
	localparam int FLT_POL_BIT = 2;
	localparam int FLT_SRC_LSB = 3;
	localparam int FLT_DAT_LSB = 4;
	localparam int LEB_LO_FALL_BIT = 12;
	localparam int LEB_LIM_EN_BIT = 10;
	localparam int LEB_FLT_EN_BIT = 11;
	localparam int LEB_SEL_LOW_BIT = 4;
	localparam int LEB_SEL_HIGH_BIT = 5;
	localparam int AUX_CHOP_SEL_LSB = 2;
	localparam int AUX_BLANK_SEL_LSB = 8;
	localparam logic [15:0] FLT_CTL_RESET = 16'h00F8;
	localparam logic [15:0] FLT_CTL_MASK = 16'h7FFF;
	localparam logic [15:0] LEB_CTL_MASK = 16'hFC3F;
	localparam logic [15:0] LEB_DLY_MASK = 16'h0FFF;
	localparam logic [15:0] AUX_CTL_MASK = 16'h0F3F;
	localparam logic [15:0] DAT_CTL_MASK = 16'h0030;
	localparam logic [31:0] UNLOCK_KEY1 = 32'h0000ABCD;
	localparam logic [31:0] UNLOCK_KEY2 = 32'h00004321;
	// ==========================================
	// codes
	localparam logic [1:0] FMODE_LATCH = 2'h0;
	localparam logic [1:0] FMODE_CYCLE = 2'h1;
	localparam logic [1:0] FMODE_OFF = 2'h3;
	localparam logic [4:0] FSRC_FAULT32 = 5'h1F;
	localparam logic [4:0] FSRC_CMP_FIRST = 5'h08;
	localparam logic [4:0] FSRC_CMP_LAST = 5'h0C;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	localparam int N_IRQ = 3;
	typedef enum logic [1:0] {LOCK_IDLE, LOCK_KEY1, LOCK_OPEN} pwmfbc_lock_t;
endpackage : pwmfbc_pkg

// file: src/pwmfbc_top.sv
// Summary of operation
// - a 5-bit source select picks fault 1-8, comparators 1-5 or fault 32 (reset default).
// - polarity bit set treats the chosen fault as active low, clear as active high.
// - fault mode 11 ignores the fault; 10 is reserved and also ignores it.
// - fault mode 01 forces both outputs to fault data only while the fault is active.
// - fault mode 00 latches the forced fault state until software clears it.
// - with the write lock strap set, control writes are refused until unlocked.
// - four enables choose which output edges restart the blanking counter.
// - edge blanking applies to fault and limit inputs only when each enable is set.
// - the blanking delay is 12 bits and its upper four bits read zero.
// - blank-on-high and blank-on-low blank inputs by the selected blank signal level.
// - four enables blank inputs while an output is at a chosen level.
// - a 4-bit select picks no state blanking or generator 1-3 high output.
// - a 4-bit select picks the internal chop clock or generator 1-3 high output.
// - separate enables let the chop signal gate the high and/or low output.
// - during a fault the high output takes the upper and low the lower fault data bit.
`timescale 1ns/1ps
module pwmfbc_top
	import pwmfbc_pkg::*;
#(
	parameter int DLY_W = 12
) (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CE_IN,
	input wire logic LOCK_STRAP_IN,
	input wire logic PWM_MODULE_ENABLE_IN,
	input wire logic PWM_HIGH_IN,
	input wire logic PWM_LOW_IN,
	input wire logic [7:0] FAULT_PINS_IN,
	input wire logic [4:0] CMP_OUTS_IN,
	input wire logic FAULT32_IN,
	input wire logic LIMIT_IN,
	input wire logic [2:0] GEN_HIGH_IN,
	input wire logic CHOP_CLK_IN,
	input wire logic [4:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [4:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	output logic PWM_HIGH_OUT,
	output logic PWM_LOW_OUT,
	output logic FAULT_ACTIVE_OUT,
	output logic LIMIT_BLANKED_OUT,
	output logic IRQ_OUT
);
	// ==========================================
	// registers
	logic [15:0] flt_ctl_reg, leb_ctl_reg, leb_dly_reg, aux_ctl_reg;
	logic [N_IRQ-1:0] status_reg, mask_reg;
	logic lock_strap_reg;
	pwmfbc_lock_t lock_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_have_reg, w_have_reg;
	logic [DLY_W-1:0] leb_cnt_reg;
	logic hi_prev_reg, lo_prev_reg;
	logic flt_latch_reg, flt_prev_reg;
	logic flt_clr_reg;

	// ==========================================
	// decode helpers
	function automatic logic [15:0] wmerge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s, input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		return v & m;
	endfunction : wmerge

	function automatic logic gen_pick(input logic [3:0] sel,
		input logic [2:0] gh, input logic zero_val);
		logic r;
		r = 1'b0;
		unique case (sel)
			4'h0: r = zero_val;
			4'h1: r = gh[0];
			4'h2: r = gh[1];
			4'h3: r = gh[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : gen_pick

	// ==========================================
	// fault source selection
	logic [4:0] fsrc;
	logic [1:0] fmode;
	logic fsel_raw, fsel_act;
	assign fsrc = flt_ctl_reg[FLT_SRC_LSB +: 5];
	assign fmode = flt_ctl_reg[FLT_MODE_LSB +: 2];
	always_comb begin
		fsel_raw = 1'b0;
		if (fsrc < FSRC_CMP_FIRST) begin
			fsel_raw = FAULT_PINS_IN[fsrc[2:0]];
		end else if (fsrc <= FSRC_CMP_LAST) begin
			fsel_raw = CMP_OUTS_IN[3'(fsrc - FSRC_CMP_FIRST)];
		end else if (fsrc == FSRC_FAULT32) begin
			fsel_raw = FAULT32_IN;
		end
	end
	// polarity must be static while enabled
	assign fsel_act = fsel_raw ^ flt_ctl_reg[FLT_POL_BIT];

	// ==========================================
	// blanking
	logic [3:0] edge_en;
	logic [3:0] edges;
	logic edge_trig, leb_busy, blank_sig, state_blank;
	logic fault_blk, limit_blk, fault_eff;
	assign edge_en = leb_ctl_reg[LEB_LO_FALL_BIT +: 4];
	assign edges = {PWM_HIGH_IN & ~hi_prev_reg, ~PWM_HIGH_IN & hi_prev_reg,
		PWM_LOW_IN & ~lo_prev_reg, ~PWM_LOW_IN & lo_prev_reg};
	assign edge_trig = |(edges & edge_en);
	assign leb_busy = (leb_cnt_reg != '0);
	assign blank_sig = gen_pick(aux_ctl_reg[AUX_BLANK_SEL_LSB +: 4],
		GEN_HIGH_IN, 1'b0);
	assign state_blank =
		(aux_ctl_reg[AUX_BLANK_SEL_LSB +: 4] != 4'h0 &&
		((leb_ctl_reg[LEB_SEL_HIGH_BIT] & blank_sig) |
		(leb_ctl_reg[LEB_SEL_LOW_BIT] & ~blank_sig))) |
		(leb_ctl_reg[3] & PWM_HIGH_IN) | (leb_ctl_reg[2] & ~PWM_HIGH_IN) |
		(leb_ctl_reg[1] & PWM_LOW_IN) | (leb_ctl_reg[0] & ~PWM_LOW_IN);
	assign fault_blk = (leb_busy & leb_ctl_reg[LEB_FLT_EN_BIT]) | state_blank;
	assign limit_blk = (leb_busy & leb_ctl_reg[LEB_LIM_EN_BIT]) | state_blank;
	assign fault_eff = fsel_act & ~fault_blk & (fmode == FMODE_LATCH ||
		fmode == FMODE_CYCLE);

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			leb_cnt_reg <= '0;
			hi_prev_reg <= 1'b0;
			lo_prev_reg <= 1'b0;
		end else if (CE_IN) begin
			hi_prev_reg <= PWM_HIGH_IN;
			lo_prev_reg <= PWM_LOW_IN;
			if (edge_trig) begin
				leb_cnt_reg <= leb_dly_reg[DLY_W-1:0];
			end else if (leb_busy) begin
				leb_cnt_reg <= leb_cnt_reg - 1'b1;
			end
		end
	end

	// ==========================================
	// fault latch and output stage
	logic fault_force, chop_sig, hi_val, lo_val;
	assign fault_force = fault_eff | flt_latch_reg;
	assign chop_sig = gen_pick(aux_ctl_reg[AUX_CHOP_SEL_LSB +: 4],
		GEN_HIGH_IN, CHOP_CLK_IN);
	always_comb begin
		hi_val = PWM_HIGH_IN & (~aux_ctl_reg[1] | chop_sig);
		lo_val = PWM_LOW_IN & (~aux_ctl_reg[0] | chop_sig);
		if (fault_force) begin
			hi_val = flt_ctl_reg[FLT_DAT_LSB + 1];
			lo_val = flt_ctl_reg[FLT_DAT_LSB];
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			flt_latch_reg <= 1'b0;
			flt_prev_reg <= 1'b0;
			PWM_HIGH_OUT <= 1'b0;
			PWM_LOW_OUT <= 1'b0;
			FAULT_ACTIVE_OUT <= 1'b0;
			LIMIT_BLANKED_OUT <= 1'b0;
		end else if (CE_IN) begin
			flt_prev_reg <= fault_eff;
			if (fault_eff && fmode == FMODE_LATCH) begin
				flt_latch_reg <= 1'b1;
			end else if (flt_clr_reg || fmode != FMODE_LATCH) begin
				flt_latch_reg <= 1'b0;
			end
			PWM_HIGH_OUT <= hi_val;
			PWM_LOW_OUT <= lo_val;
			FAULT_ACTIVE_OUT <= fault_force;
			LIMIT_BLANKED_OUT <= LIMIT_IN & limit_blk;
		end
	end

	// ==========================================
	// axi4-lite write channel
	logic wr_fire, wr_ok, ctl_wr;
	logic [7:0] rd_addr;
	assign wr_fire = aw_have_reg && w_have_reg && !BVALID_OUT;
	assign ctl_wr = aw_addr_reg[7:4] == 4'h0;
	assign wr_ok = !ctl_wr || !lock_strap_reg || lock_reg == LOCK_OPEN;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			AWREADY_OUT <= 1'b1;
			WREADY_OUT <= 1'b1;
			BVALID_OUT <= 1'b0;
			BRESP_OUT <= AXI_OKAY;
		end else if (CE_IN) begin
			if (AWVALID_IN && AWREADY_OUT) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= {3'h0, AWADDR_IN};
				AWREADY_OUT <= 1'b0;
			end
			if (WVALID_IN && WREADY_OUT) begin
				w_have_reg <= 1'b1;
				w_data_reg <= WDATA_IN;
				w_strb_reg <= WSTRB_IN;
				WREADY_OUT <= 1'b0;
			end
			if (wr_fire) begin
				BVALID_OUT <= 1'b1;
				BRESP_OUT <= wr_ok ? AXI_OKAY : AXI_SLVERR;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
			if (BVALID_OUT && BREADY_IN) begin
				BVALID_OUT <= 1'b0;
				AWREADY_OUT <= 1'b1;
				WREADY_OUT <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			flt_ctl_reg <= FLT_CTL_RESET;
			leb_ctl_reg <= 16'h0000;
			leb_dly_reg <= 16'h0000;
			aux_ctl_reg <= 16'h0000;
			mask_reg <= '0;
			flt_clr_reg <= 1'b0;
		end else if (CE_IN) begin
			flt_clr_reg <= 1'b0;
			if (wr_fire && wr_ok) begin
				unique case (aw_addr_reg)
					{4'h0, ADDR_FLT_CTL}: flt_ctl_reg <= wmerge(flt_ctl_reg,
						w_data_reg, w_strb_reg, FLT_CTL_MASK);
					{4'h0, ADDR_LEB_CTL}: leb_ctl_reg <= wmerge(leb_ctl_reg,
						w_data_reg, w_strb_reg, LEB_CTL_MASK);
					{4'h0, ADDR_LEB_DLY}: leb_dly_reg <= wmerge(leb_dly_reg,
						w_data_reg, w_strb_reg, LEB_DLY_MASK);
					{4'h0, ADDR_AUX_CTL}: aux_ctl_reg <= wmerge(aux_ctl_reg,
						w_data_reg, w_strb_reg, AUX_CTL_MASK);
					ADDR_MASK: mask_reg <= w_data_reg[N_IRQ-1:0];
					default: flt_clr_reg <= (aw_addr_reg == ADDR_FLT_CLR) &&
						w_data_reg[0];
				endcase
			end
		end
	end

	// unlock: key1 then key2 to unlock register, opens one write
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			lock_reg <= LOCK_IDLE;
			lock_strap_reg <= 1'b0;
		end else if (CE_IN) begin
			lock_strap_reg <= LOCK_STRAP_IN;
			if (wr_fire) begin
				unique case (lock_reg)
					LOCK_IDLE: lock_reg <= (aw_addr_reg == ADDR_UNLOCK &&
						w_data_reg == UNLOCK_KEY1) ? LOCK_KEY1 : LOCK_IDLE;
					LOCK_KEY1: lock_reg <= (aw_addr_reg == ADDR_UNLOCK &&
						w_data_reg == UNLOCK_KEY2) ? LOCK_OPEN : LOCK_IDLE;
					LOCK_OPEN: lock_reg <= ctl_wr ? LOCK_IDLE : LOCK_OPEN;
				endcase
			end
		end
	end

	// ==========================================
	// interrupts and read channel
	logic [N_IRQ-1:0] ev;
	logic rd_stat;
	logic [31:0] rd_val;
	assign ev = {fault_eff & ~flt_prev_reg, LIMIT_IN & limit_blk, edge_trig};
	assign rd_addr = {3'h0, ARADDR_IN};
	assign rd_stat = ARVALID_IN && ARREADY_OUT && rd_addr == ADDR_STATUS;
	always_comb begin
		rd_val = 32'h00000000;
		unique case (rd_addr)
			{4'h0, ADDR_FLT_CTL}: rd_val = {16'h0000, flt_ctl_reg};
			{4'h0, ADDR_LEB_CTL}: rd_val = {16'h0000, leb_ctl_reg};
			{4'h0, ADDR_LEB_DLY}: rd_val = {16'h0000, leb_dly_reg};
			{4'h0, ADDR_AUX_CTL}: rd_val = {16'h0000, aux_ctl_reg};
			ADDR_STATUS: rd_val = {29'h0, status_reg};
			ADDR_MASK: rd_val = {29'h0, mask_reg};
			ADDR_UNLOCK: rd_val = {28'h0, flt_latch_reg,
				lock_reg == LOCK_OPEN, lock_strap_reg, PWM_MODULE_ENABLE_IN};
			default: rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			status_reg <= '0;
			IRQ_OUT <= 1'b0;
			ARREADY_OUT <= 1'b1;
			RVALID_OUT <= 1'b0;
			RDATA_OUT <= 32'h00000000;
			RRESP_OUT <= AXI_OKAY;
		end else if (CE_IN) begin
			// set wins over read clear
			status_reg <= (rd_stat ? '0 : status_reg) | ev;
			IRQ_OUT <= |(((rd_stat ? '0 : status_reg) | ev) & mask_reg);
			if (ARVALID_IN && ARREADY_OUT) begin
				ARREADY_OUT <= 1'b0;
				RVALID_OUT <= 1'b1;
				RDATA_OUT <= rd_val;
				RRESP_OUT <= (rd_addr[1:0] == 2'h0 && rd_addr <= ADDR_FLT_CLR)
					? AXI_OKAY : AXI_SLVERR;
			end else if (RVALID_OUT && RREADY_IN) begin
				RVALID_OUT <= 1'b0;
				ARREADY_OUT <= 1'b1;
			end
		end
	end
endmodule : pwmfbc_top

// file: bench/pwmfbc_props.sv
`timescale 1ns/1ps
module pwmfbc_props
	import pwmfbc_pkg::*;
#(
	parameter int DLY_W = 12
) (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [1:0] RRESP_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic LIMIT_IN,
	input wire logic LIMIT_BLANKED_OUT
);
	// ==========
	// blanking run length
	logic [15:0] run_reg;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			run_reg <= 16'h0000;
		end else begin
			run_reg <= LIMIT_BLANKED_OUT ? run_reg + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	sequence wr_taken;
		AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	endsequence
	sequence wr_walk;
		!AWREADY_OUT && !WREADY_OUT ##1 BVALID_OUT;
	endsequence
	wr_answer_a: assert property (wr_taken |=> wr_walk)
		else $error("write walk broken");
	rd_answer_a: assert property (ARVALID_IN && ARREADY_OUT |=>
		RVALID_OUT && !ARREADY_OUT) else $error("read answer late");
	b_release_a: assert property (BVALID_OUT && BREADY_IN |=>
		!BVALID_OUT ##1 AWREADY_OUT && WREADY_OUT)
		else $error("write release wrong");
	r_release_a: assert property (RVALID_OUT && RREADY_IN |=> !RVALID_OUT)
		else $error("read release wrong");
	bresp_legal_a: assert property (BVALID_OUT |->
		BRESP_OUT == AXI_OKAY || BRESP_OUT == AXI_SLVERR)
		else $error("bad write response");
	rresp_legal_a: assert property (RVALID_OUT |->
		RRESP_OUT == AXI_OKAY || RRESP_OUT == AXI_SLVERR)
		else $error("bad read response");
	limit_cause_a: assert property (LIMIT_BLANKED_OUT |-> $past(LIMIT_IN))
		else $error("blanked limit without limit");
	blank_len_a: assert property (run_reg <= 16'(1 << DLY_W))
		else $error("blanking too long");
endmodule : pwmfbc_props
bind pwmfbc_top pwmfbc_props #(.DLY_W(DLY_W)) i_pwmfbc_props (.*);

// file: bench/pwmfbc_stage.sv
`timescale 1ns/1ps
module pwmfbc_stage (
	input wire logic clk_in,
	input wire logic [4:0] sel_in,
	input wire logic on_in,
	input wire logic limit_on_in,
	output logic [7:0] pins_out,
	output logic [4:0] cmp_out,
	output logic f32_out,
	output logic limit_out
);
	logic [14:0] v;
	// comparators settle one clock late
	always_ff @(posedge clk_in) begin
		v[13:0] <= on_in ? 14'h0001 << (sel_in == 5'h1F ? 5'h0D : sel_in) : 14'h0;
		v[14] <= limit_on_in;
	end
	assign pins_out = v[7:0];
	assign cmp_out = v[12:8];
	assign f32_out = v[13];
	assign limit_out = v[14];
endmodule : pwmfbc_stage

// file: bench/pwmfbc_top_bench.sv
`timescale 1ns/1ps
module pwmfbc_top_bench
	import pwmfbc_pkg::*;
;
	logic CLK_IN = 0, RST_B_IN = 0, CE_IN = 1, LOCK_STRAP_IN = 0;
	logic PWM_MODULE_ENABLE_IN = 0;
	logic PWM_HIGH_IN = 0, PWM_LOW_IN = 0, CHOP_CLK_IN = 0;
	logic [2:0] GEN_HIGH_IN = 0;
	logic [7:0] FAULT_PINS_IN;
	logic [4:0] CMP_OUTS_IN;
	logic FAULT32_IN, LIMIT_IN;
	logic [4:0] AWADDR_IN = 0;
	logic [3:0] WSTRB_IN = 0;
	logic AWVALID_IN = 0, WVALID_IN = 0, BREADY_IN = 0;
	logic [31:0] WDATA_IN = 0, RDATA_OUT;
	logic [4:0] ARADDR_IN = 0, f_sel = 0;
	logic ARVALID_IN = 0, RREADY_IN = 0, f_on = 0, lim_on = 0;
	logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
	logic [1:0] BRESP_OUT, RRESP_OUT;
	logic PWM_HIGH_OUT, PWM_LOW_OUT, FAULT_ACTIVE_OUT, LIMIT_BLANKED_OUT;
	logic IRQ_OUT;
	int n_mismatch = 0, n_compared = 0;
	pwmfbc_top i_pwmfbc_top (.*);
	pwmfbc_stage i_pwmfbc_stage (.clk_in(CLK_IN), .sel_in(f_sel),
		.on_in(f_on), .limit_on_in(lim_on), .pins_out(FAULT_PINS_IN),
		.cmp_out(CMP_OUTS_IN), .f32_out(FAULT32_IN), .limit_out(LIMIT_IN));
	always #20 CLK_IN = ~CLK_IN;
	// ==========
	// shared tasks
	task automatic test_done;
		if (n_mismatch == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d,
		input logic [1:0] er);
		int i;
		@(posedge CLK_IN);
		AWADDR_IN <= a;
		WDATA_IN <= {16'h0000, d};
		WSTRB_IN <= 4'h3;
		AWVALID_IN <= 1'h1;
		WVALID_IN <= 1'h1;
		BREADY_IN <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK_IN);
			if (AWREADY_OUT) AWVALID_IN <= 1'h0;
			if (WREADY_OUT) WVALID_IN <= 1'h0;
			if (BVALID_OUT) break;
		end
		BREADY_IN <= 1'h0;
		if (i == 64) begin chk("timeout", 0, 1); test_done(); end
		chk("bresp", er, BRESP_OUT);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] e,
		input string nm);
		int i;
		@(posedge CLK_IN);
		ARADDR_IN <= a;
		ARVALID_IN <= 1'h1;
		RREADY_IN <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK_IN);
			if (ARREADY_OUT) ARVALID_IN <= 1'h0;
			if (RVALID_OUT) break;
		end
		RREADY_IN <= 1'h0;
		if (i == 64) begin chk("timeout", 0, 1); test_done(); end
		chk(nm, e, RDATA_OUT);
	endtask : rd
	task automatic settle(input int n);
		repeat (n) @(posedge CLK_IN);
		@(negedge CLK_IN);
	endtask : settle
	// ==========
	// scenarios
	task automatic flt(input logic [15:0] c, input logic [4:0] s,
		input logic on, input logic ea);
		wr(4'h0, c, AXI_OKAY);
		@(posedge CLK_IN);
		f_sel <= s;
		f_on <= on;
		settle(3);
		chk("fault_active", ea, FAULT_ACTIVE_OUT);
		chk("outs", ea ? c[5:4] : 2'h0, {PWM_HIGH_OUT, PWM_LOW_OUT});
	endtask : flt
	task automatic lock_case;
		@(posedge CLK_IN);
		LOCK_STRAP_IN <= 1'h1;
		settle(2);
		wr(4'h0, 16'h0033, AXI_SLVERR);
		rd(5'h00, 32'h00000031, "locked_keep");
		wr(5'h18, 16'hABCD, AXI_OKAY);
		wr(5'h18, 16'h4321, AXI_OKAY);
		wr(5'h00, 16'h0033, AXI_OKAY);
		rd(5'h00, 32'h00000033, "unlocked_write");
		@(posedge CLK_IN);
		LOCK_STRAP_IN <= 1'h0;
	endtask : lock_case
	task automatic edge_count(input logic lvl, input int e, input string nm);
		int i, n;
		@(posedge CLK_IN);
		PWM_HIGH_IN <= lvl;
		n = 0;
		for (i = 0; i < 30; i++) begin
			@(posedge CLK_IN);
			n += (LIMIT_BLANKED_OUT === 1'h1);
		end
		chk(nm, e, n);
	endtask : edge_count
	task automatic blank_case;
		wr(4'h0, 16'h0033, AXI_OKAY);
		wr(4'h8, 16'hF005, AXI_OKAY);
		rd(5'h08, 32'h00000005, "dly_upper");
		rd(5'h10, 32'h00000004, "status_fault");
		wr(4'h4, 16'h8400, AXI_OKAY);
		@(posedge CLK_IN);
		lim_on <= 1'h1;
		settle(3);
		chk("no_edge", 0, LIMIT_BLANKED_OUT);
		edge_count(1'h1, 5, "rise_blank");
		edge_count(1'h0, 0, "fall_ignored");
		wr(4'h4, 16'h8000, AXI_OKAY);
		edge_count(1'h1, 0, "limit_off");
		wr(5'h14, 16'h0003, AXI_OKAY);
		settle(1);
		chk("irq_set", 1, IRQ_OUT);
		rd(5'h10, 32'h00000003, "status_blank");
		rd(5'h10, 32'h00000000, "status_clear");
		settle(1);
		chk("irq_clear", 0, IRQ_OUT);
	endtask : blank_case
	task automatic state_case;
		wr(5'h04, 16'h0008, AXI_OKAY);
		settle(2);
		chk("blank_hi_high", 1, LIMIT_BLANKED_OUT);
		wr(5'h04, 16'h0020, AXI_OKAY);
		settle(2);
		chk("blank_sel_none", 0, LIMIT_BLANKED_OUT);
		wr(5'h0C, 16'h0100, AXI_OKAY);
		settle(2);
		chk("blank_sel_gen1", 1, LIMIT_BLANKED_OUT);
		wr(5'h0C, 16'h0300, AXI_OKAY);
		settle(2);
		chk("blank_sel_gen3", 0, LIMIT_BLANKED_OUT);
	endtask : state_case
	task automatic chop_case;
		int k;
		@(posedge CLK_IN);
		PWM_LOW_IN <= 1'h1;
		for (k = 0; k < 4; k++) begin
			wr(4'hC, 16'(k * 4 + 2), AXI_OKAY);
			@(posedge CLK_IN);
			{GEN_HIGH_IN, CHOP_CLK_IN} <= 4'h1 << k;
			settle(2);
			chk("chop_on", 2'h3, {PWM_HIGH_OUT, PWM_LOW_OUT});
			@(posedge CLK_IN);
			{GEN_HIGH_IN, CHOP_CLK_IN} <= ~(4'h1 << k);
			settle(2);
			chk("chop_off", 2'h1, {PWM_HIGH_OUT, PWM_LOW_OUT});
		end
	endtask : chop_case
	initial begin
		repeat (12) @(posedge CLK_IN);
		RST_B_IN <= 1'h1;
		rd(5'h00, 32'h000000F8, "fault_ctl_reset");
		flt(16'h0031, 5'h06, 1'h1, 1'h1);
		flt(16'h0031, 5'h06, 1'h0, 1'h0);
		flt(16'h0031, 5'h05, 1'h1, 1'h0);
		flt(16'h0041, 5'h08, 1'h1, 1'h1);
		flt(16'h00F9, 5'h1F, 1'h1, 1'h1);
		flt(16'h0035, 5'h06, 1'h0, 1'h1);
		flt(16'h0035, 5'h06, 1'h1, 1'h0);
		flt(16'h0033, 5'h06, 1'h1, 1'h0);
		flt(16'h0032, 5'h06, 1'h1, 1'h0);
		flt(16'h0030, 5'h06, 1'h1, 1'h1);
		flt(16'h0030, 5'h06, 1'h0, 1'h1);
		wr(5'h1C, 16'h0001, AXI_OKAY);
		settle(2);
		chk("latch_clear", 0, FAULT_ACTIVE_OUT);
		flt(16'h0031, 5'h06, 1'h0, 1'h0);
		lock_case();
		blank_case();
		chop_case();
		state_case();
		test_done();
	end
endmodule : pwmfbc_top_bench
